// ===== src/e3_rx_defect_interrupts.sv
// Receive defect detection, interrupt status and Avalon-MM register slave
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
// Contract
// - Frame loss enable sits at layout bit 2
// - Enable one passes source, zero blocks it
// - Enable register: bits 4..0 writable, 7..5 zero
// - Enabled pending event drives IRQ_N low
// - Frame loss event sets status bit 2
// - Status register: five sticky bits, 7..5 zero
// - Live register: writable timer select, live flags
// - Four errored frames in a row: slip
// - Keep old alignment until new one found
// - Raise alignment event when offset changes
// - Alignment enable bit 4, one enables
// - Alignment event sets status bit 4
// - Alarm event on declare and on clear
// - Declare alarm: two frames, seven zeros or fewer
// - Clear alarm: two frames each eight zeros
// - Frame loss event on declare and clear
// - Frame loss after slip lasting 1 or 3 ms
module e3_rx_defect_interrupts
    import rx_defect_pkg::*;
#(
    parameter int unsigned ZERO_W = 11,
    parameter int unsigned OFFSET_W = 11,
    parameter logic [TIMER_W-1:0] SHORT_CYC = TIMER_W'(LOSS_SHORT_CYC),
    parameter logic [TIMER_W-1:0] LONG_CYC = TIMER_W'(LOSS_LONG_CYC)
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [DATA_W-1:0] AVS_WRITEDATA,
    output logic [DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic FRAME_END,
    input wire logic FRAME_ALIGN_ERR,
    input wire logic [ZERO_W-1:0] FRAME_ZERO_COUNT,
    input wire logic SYNC_FOUND,
    input wire logic [OFFSET_W-1:0] SYNC_OFFSET,
    input wire logic SIGNAL_LOSS,
    input wire logic PAYLOAD_UNSTABLE,
    input wire logic TRACE_MARK,
    input wire logic FAR_END_FAIL,
    output logic [OFFSET_W-1:0] ALIGN_OFFSET,
    output logic IRQ_N
);

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx[ADDR_W-3:0]);
    endfunction : hit

    // Bus slave state
    logic wait_r;
    logic [DATA_W-1:0] rdata_r;
    logic [4:0] enable_r;
    logic timer_sel_r;
    logic [4:0] status_r;
    logic [4:0] status_nxt;
    logic irq_n_r;

    // Framing state
    frame_state_t state_r;
    frame_state_t state_nxt;
    logic [2:0] err_run_r;
    logic [2:0] err_run_nxt;
    logic [TIMER_W-1:0] timer_r;
    logic [TIMER_W-1:0] timer_nxt;
    logic [OFFSET_W-1:0] offset_r;
    logic alarm_r;
    logic alarm_nxt;
    logic [ZERO_W-1:0] prev_zero_r;
    logic prev_valid_r;
    logic signal_prev_r;

    // Bus decode
    wire req = AVS_READ | AVS_WRITE;
    wire accept = req & ~wait_r;
    wire sel_live = hit(AVS_ADDRESS, IDX_LIVE_FLAGS);
    wire sel_en = hit(AVS_ADDRESS, IDX_IRQ_ENABLE);
    wire sel_stat = hit(AVS_ADDRESS, IDX_IRQ_STATUS);
    wire wr_live = accept & AVS_WRITE & sel_live;
    wire wr_en = accept & AVS_WRITE & sel_en;
    wire rd_stat = accept & AVS_READ & sel_stat;

    wire lost = (state_r == LOST);
    wire slipped = (state_r != IN_FRAME);

    wire [DATA_W-1:0] live_word = {
        timer_sel_r, lost, slipped, SIGNAL_LOSS,
        alarm_r, PAYLOAD_UNSTABLE, TRACE_MARK, FAR_END_FAIL
    };
    wire [DATA_W-1:0] rd_mux =
        sel_live ? live_word :
        sel_en ? {3'h0, enable_r} :
        sel_stat ? {3'h0, status_r} :
        8'h00;

    // Slip detection over consecutive errored frames
    wire [2:0] run_inc = (err_run_r == 3'(SLIP_FRAMES)) ? err_run_r : err_run_r + 3'h1;
    assign err_run_nxt = !FRAME_END ? err_run_r :
                         FRAME_ALIGN_ERR ? run_inc : 3'h0;
    wire slip_hit = FRAME_END & FRAME_ALIGN_ERR & (run_inc == 3'(SLIP_FRAMES));

    // Frame loss window
    wire [TIMER_W-1:0] loss_limit = timer_sel_r ? LONG_CYC : SHORT_CYC;
    wire timer_done = (timer_r >= loss_limit - TIMER_W'(1));
    wire realigned = slipped & SYNC_FOUND;

    always_comb begin
        state_nxt = state_r;
        timer_nxt = timer_r;
        case (state_r)
            IN_FRAME: begin
                timer_nxt = '0;
                if (slip_hit) begin
                    state_nxt = SLIPPED;
                end
            end
            SLIPPED: begin
                timer_nxt = timer_r + TIMER_W'(1);
                if (SYNC_FOUND) begin
                    state_nxt = IN_FRAME;
                end else if (timer_done) begin
                    state_nxt = LOST;
                end
            end
            LOST: begin
                timer_nxt = '0;
                if (SYNC_FOUND) begin
                    state_nxt = IN_FRAME;
                end
            end
            default: begin
                state_nxt = IN_FRAME;
                timer_nxt = '0;
            end
        endcase
    end

    // Alarm indication over two-frame windows
    wire [ZERO_W:0] pair_zeros = {1'b0, prev_zero_r} + {1'b0, FRAME_ZERO_COUNT};
    wire alarm_set = prev_valid_r & (pair_zeros <= (ZERO_W+1)'(ALARM_MAX_ZEROS));
    wire alarm_clr = prev_valid_r & (prev_zero_r >= ZERO_W'(ALARM_CLR_ZEROS))
                     & (FRAME_ZERO_COUNT >= ZERO_W'(ALARM_CLR_ZEROS));
    assign alarm_nxt = !FRAME_END ? alarm_r :
                       alarm_r ? ~alarm_clr : alarm_set;

    // Events
    wire [4:0] events;
    assign events[SRC_ALARM] = alarm_nxt ^ alarm_r;
    assign events[SRC_SIGNAL] = SIGNAL_LOSS ^ signal_prev_r;
    assign events[SRC_FRAME_LOSS] = (state_nxt == LOST) ^ lost;
    assign events[SRC_FRAME_SLIP] = (state_nxt != IN_FRAME) ^ slipped;
    assign events[SRC_ALIGN] = realigned & (SYNC_OFFSET != offset_r);

    // Sticky status, set wins over read clear; only bits already read are cleared
    wire [4:0] clr_mask = rd_stat ? rdata_r[4:0] : 5'h00;
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_stat
            assign status_nxt[g] = events[g] | (status_r[g] & ~clr_mask[g]);
        end
    endgenerate

    wire irq_any = |(status_nxt & enable_r);

    always_ff @(posedge CLK) begin
        if (RST) begin
            wait_r <= 1'b1;
            rdata_r <= 8'h00;
        end else begin
            wait_r <= ~(req & wait_r);
            if (req & wait_r) begin
                rdata_r <= AVS_READ ? rd_mux : 8'h00;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            enable_r <= ENABLE_RST;
            timer_sel_r <= TIMER_SEL_RST;
        end else begin
            if (wr_en) begin
                enable_r <= AVS_WRITEDATA[4:0];
            end
            if (wr_live) begin
                timer_sel_r <= AVS_WRITEDATA[LF_TIMER_SEL];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            status_r <= STATUS_RST;
            irq_n_r <= 1'b1;
            signal_prev_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq_n_r <= ~irq_any;
            signal_prev_r <= SIGNAL_LOSS;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_r <= IN_FRAME;
            err_run_r <= 3'h0;
            timer_r <= '0;
            offset_r <= '0;
        end else begin
            state_r <= state_nxt;
            err_run_r <= realigned ? 3'h0 : err_run_nxt;
            timer_r <= timer_nxt;
            if (realigned) begin
                offset_r <= SYNC_OFFSET;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            alarm_r <= 1'b0;
            prev_zero_r <= '0;
            prev_valid_r <= 1'b0;
        end else begin
            alarm_r <= alarm_nxt;
            if (FRAME_END) begin
                prev_zero_r <= FRAME_ZERO_COUNT;
                prev_valid_r <= 1'b1;
            end
        end
    end

    assign AVS_READDATA = rdata_r;
    assign AVS_WAITREQUEST = wait_r;
    assign ALIGN_OFFSET = offset_r;
    assign IRQ_N = irq_n_r;

endmodule : e3_rx_defect_interrupts

// ===== src/rx_defect_pkg.sv
// Register map, field positions and timing constants for the receive defect block
package rx_defect_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_LIVE_FLAGS = 8'h11;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h12;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h14;
    // Interrupt source bits, shared by enable and status
    localparam int unsigned SRC_ALARM = 0;
    localparam int unsigned SRC_SIGNAL = 1;
    localparam int unsigned SRC_FRAME_LOSS = 2;
    localparam int unsigned SRC_FRAME_SLIP = 3;
    localparam int unsigned SRC_ALIGN = 4;
    localparam int unsigned NUM_SRC = 5;
    // Live flag register fields
    localparam int unsigned LF_TIMER_SEL = 7;
    localparam int unsigned LF_FRAME_LOSS = 6;
    localparam int unsigned LF_FRAME_SLIP = 5;
    localparam int unsigned LF_SIGNAL = 4;
    localparam int unsigned LF_ALARM = 3;
    localparam int unsigned LF_PAYLOAD = 2;
    localparam int unsigned LF_TRACE = 1;
    localparam int unsigned LF_FAR_END = 0;
    // Reset values
    localparam logic [4:0] ENABLE_RST = 5'h00;
    localparam logic [4:0] STATUS_RST = 5'h00;
    localparam logic TIMER_SEL_RST = 1'b0;
    // Framing and alarm thresholds
    localparam int unsigned SLIP_FRAMES = 4;
    localparam int unsigned ALARM_MAX_ZEROS = 7;
    localparam int unsigned ALARM_CLR_ZEROS = 8;
    // Frame loss windows
    localparam int unsigned LOSS_SHORT_US = 1000;
    localparam int unsigned LOSS_LONG_US = 3000;
    localparam int unsigned LOSS_SHORT_CYC = LOSS_SHORT_US * (CLK_HZ / 1000000);
    localparam int unsigned LOSS_LONG_CYC = LOSS_LONG_US * (CLK_HZ / 1000000);
    localparam int unsigned TIMER_W = 20;
    typedef enum logic [1:0] {
        IN_FRAME = 2'b00,
        SLIPPED = 2'b01,
        LOST = 2'b10
    } frame_state_t;
endpackage : rx_defect_pkg

// ===== tb/host_bfm.sv
// Avalon-MM host model servicing the register slave
`timescale 1ns/1ps
module host_bfm
    import rx_defect_pkg::*;
(
    input wire logic clk,
    input wire logic waitreq,
    input wire logic [DATA_W-1:0] rdata,
    output logic [ADDR_W-1:0] addr = '0,
    output logic rd = 1'b0,
    output logic wr = 1'b0,
    output logic [DATA_W-1:0] wdata = '0
);
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q, output bit ok);
        ok = 1'b0;
        {rd, wr, addr, wdata} <= {!w, w, a, d};
        for (int i = 0; i < 16 && !ok; i++) begin
            @(posedge clk);
            ok = waitreq === 1'b0;
        end
        q = rdata;
        {rd, wr} <= 2'b00;
        // Idle cycle so the next request never lands in this time step
        @(posedge clk);
    endtask : xfer
endmodule : host_bfm

// ===== tb/rx_defect_chk.sv
// Port assertions for the receive defect block
`timescale 1ns/1ps
module rx_defect_chk
    import rx_defect_pkg::*;
#(parameter int unsigned OFFSET_W = 11) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [DATA_W-1:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic SYNC_FOUND,
    input wire logic [OFFSET_W-1:0] SYNC_OFFSET,
    input wire logic [OFFSET_W-1:0] ALIGN_OFFSET,
    input wire logic IRQ_N
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    wire rd_ok = AVS_READ && !AVS_WAITREQUEST;
    wire st_clr = rd_ok && AVS_ADDRESS == 8'h50;
    wire en_set = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h48;
    wire odd = !(AVS_ADDRESS inside {8'h44, 8'h48, 8'h50});
    sequence req_s;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    sequence acc_s;
        (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
    endsequence
    AST_WAIT_ONE: assert property (req_s |=> !AVS_WAITREQUEST)
        else $error("late answer");
    AST_WAIT_PULSE: assert property (acc_s |=> AVS_WAITREQUEST)
        else $error("long answer");
    AST_EN_PAD: assert property (rd_ok && AVS_ADDRESS == 8'h48 |-> AVS_READDATA[7:5] == 3'h0)
        else $error("enable pad");
    AST_ST_PAD: assert property (st_clr |-> AVS_READDATA[7:5] == 3'h0)
        else $error("status pad");
    AST_UNMAPPED: assert property (rd_ok && odd |-> AVS_READDATA == 8'h00)
        else $error("unmapped data");
    AST_ALIGN_HOLD: assert property ($changed(ALIGN_OFFSET) |-> $past(SYNC_FOUND))
        else $error("alignment moved");
    AST_ALIGN_TAKE: assert property ($changed(ALIGN_OFFSET) |-> ALIGN_OFFSET == $past(SYNC_OFFSET))
        else $error("alignment value");
    AST_IRQ_DROP: assert property ($rose(IRQ_N) |-> $past(st_clr || en_set) || $past(st_clr || en_set, 2))
        else $error("irq release");
endmodule : rx_defect_chk

bind e3_rx_defect_interrupts rx_defect_chk #(.OFFSET_W(OFFSET_W)) rx_defect_chk_i (
    .CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .SYNC_FOUND(SYNC_FOUND),
    .SYNC_OFFSET(SYNC_OFFSET), .ALIGN_OFFSET(ALIGN_OFFSET), .IRQ_N(IRQ_N));

// ===== tb/tb.sv
// Directed bench for the receive defect block
`timescale 1ns/1ps
module tb;
    import rx_defect_pkg::*;
    logic clk = 1'b0, rst = 1'b1, fend = 1'b0, ferr = 1'b0, sfound = 1'b0, sloss = 1'b0;
    logic pay = 1'b0, trace = 1'b0, far = 1'b0, rd, wr, wreq, irq_n;
    logic [10:0] zeros = 11'h064, soff = 11'h000, align;
    logic [7:0] addr, wdata, rdata;
    int fail_count = 0, check_count = 0;
    always #12.5 clk = ~clk;
    e3_rx_defect_interrupts #(.SHORT_CYC(20'd20), .LONG_CYC(20'd60)) e3_rx_defect_interrupts_i (
        .CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .FRAME_END(fend),
        .FRAME_ALIGN_ERR(ferr), .FRAME_ZERO_COUNT(zeros), .SYNC_FOUND(sfound), .SYNC_OFFSET(soff),
        .SIGNAL_LOSS(sloss), .PAYLOAD_UNSTABLE(pay), .TRACE_MARK(trace), .FAR_END_FAIL(far),
        .ALIGN_OFFSET(align), .IRQ_N(irq_n));
    host_bfm host_bfm_i (.clk(clk), .waitreq(wreq), .rdata(rdata), .addr(addr), .rd(rd),
        .wr(wr), .wdata(wdata));
    task automatic cmp(input logic [10:0] seen, input logic [10:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : cmp
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        logic [7:0] q;
        bit ok;
        host_bfm_i.xfer(w, a, d, q, ok);
        if (!ok) begin
            fail_count++;
            tally_and_finish();
        end else if (!w) cmp(q, e);
    endtask : bus
    task automatic frame(input logic err, input logic [10:0] n);
        {fend, ferr, zeros} <= {1'b1, err, n};
        @(posedge clk);
        fend <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : frame
    task automatic t_regs;
        bus(0, 8'h48, 8'h00, 8'h00);
        bus(0, 8'h50, 8'h00, 8'h00);
        bus(0, 8'h44, 8'h00, 8'h00);
        {pay, trace, far} <= 3'b111;
        bus(1, 8'h48, 8'hff, 8'h00);
        bus(0, 8'h48, 8'h00, 8'h1f);
        bus(1, 8'h44, 8'hff, 8'h00);
        bus(0, 8'h44, 8'h00, 8'h87);
        bus(0, 8'h4c, 8'h00, 8'h00);
        bus(0, 8'h51, 8'h00, 8'h00);
        $display("regs done");
    endtask : t_regs
    task automatic t_signal;
        bus(1, 8'h48, 8'h02, 8'h00);
        sloss <= 1'b1;
        repeat (4) @(posedge clk);
        cmp(irq_n, 1'b0);
        bus(0, 8'h50, 8'h00, 8'h02);
        bus(0, 8'h50, 8'h00, 8'h00);
        cmp(irq_n, 1'b1);
        bus(1, 8'h48, 8'h00, 8'h00);
        sloss <= 1'b0;
        repeat (4) @(posedge clk);
        cmp(irq_n, 1'b1);
        bus(0, 8'h50, 8'h00, 8'h02);
        $display("signal done");
    endtask : t_signal
    task automatic t_slip;
        bus(1, 8'h48, 8'h14, 8'h00);
        repeat (3) frame(1'b1, 11'h064);
        bus(0, 8'h44, 8'h00, 8'h87);
        frame(1'b1, 11'h064);
        bus(0, 8'h44, 8'h00, 8'ha7);
        cmp(irq_n, 1'b1);
        repeat (30) @(posedge clk);
        bus(0, 8'h44, 8'h00, 8'ha7);
        repeat (50) @(posedge clk);
        bus(0, 8'h44, 8'h00, 8'he7);
        cmp(irq_n, 1'b0);
        bus(0, 8'h50, 8'h00, 8'h0c);
        {sfound, soff} <= {1'b1, 11'h005};
        @(posedge clk);
        sfound <= 1'b0;
        repeat (3) @(posedge clk);
        cmp(align, 11'h005);
        bus(0, 8'h50, 8'h00, 8'h1c);
        $display("slip done");
    endtask : t_slip
    task automatic t_alarm;
        bus(1, 8'h48, 8'h01, 8'h00);
        repeat (2) frame(1'b0, 11'h003);
        bus(0, 8'h44, 8'h00, 8'h8f);
        cmp(irq_n, 1'b0);
        bus(0, 8'h50, 8'h00, 8'h01);
        frame(1'b0, 11'h008);
        bus(0, 8'h44, 8'h00, 8'h8f);
        frame(1'b0, 11'h008);
        bus(0, 8'h44, 8'h00, 8'h87);
        bus(0, 8'h50, 8'h00, 8'h01);
        $display("alarm done");
    endtask : t_alarm
    task automatic t_short;
        bus(1, 8'h48, 8'h04, 8'h00);
        bus(1, 8'h44, 8'h00, 8'h00);
        repeat (4) frame(1'b1, 11'h064);
        bus(0, 8'h44, 8'h00, 8'h27);
        repeat (20) @(posedge clk);
        bus(0, 8'h44, 8'h00, 8'h67);
        cmp(irq_n, 1'b0);
        bus(0, 8'h50, 8'h00, 8'h0c);
        {sfound, soff} <= {1'b1, 11'h005};
        @(posedge clk);
        sfound <= 1'b0;
        repeat (3) @(posedge clk);
        bus(0, 8'h50, 8'h00, 8'h0c);
        $display("short window done");
    endtask : t_short
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_signal();
        t_slip();
        t_alarm();
        t_short();
        tally_and_finish();
    end
endmodule : tb
